// file: cdcpbc_consts.vh
// Offsets, field positions, reset values and result count of the configuration bank
`ifndef CDCPBC_CONSTS_VH
`define CDCPBC_CONSTS_VH

`define CDCPBC_ADDR_W 6
`define CDCPBC_OFF_PORT 6'h21
`define CDCPBC_OFF_BGAP 6'h22
`define CDCPBC_OFF_GAIN 6'h23
`define CDCPBC_OFF_UNUSED_A 6'h24
`define CDCPBC_OFF_UNUSED_B 6'h25
`define CDCPBC_OFF_BGTIME 6'h26
`define CDCPBC_OFF_PULSE 6'h27
`define CDCPBC_OFF_CRATIO 6'h28
`define CDCPBC_OFF_RRATIO 6'h29
`define CDCPBC_OFF_ALARM 6'h2A

`define CDCPBC_PORT_DIR_MSB 7
`define CDCPBC_PORT_DIR_LSB 4
`define CDCPBC_PORT_PU_MSB 3
`define CDCPBC_PORT_PU_LSB 0
`define CDCPBC_BG_READEND 7
`define CDCPBC_BG_PROC 6
`define CDCPBC_REFERENCE_ALWAYS_ON 5
`define CDCPBC_BG_AUTO 4
`define CDCPBC_PULSE1_MSB 7
`define CDCPBC_PULSE1_LSB 4
`define CDCPBC_PULSE0_MSB 3
`define CDCPBC_PULSE0_LSB 0
`define CDCPBC_AL_B_SRC 7
`define CDCPBC_AL_B_POL 6
`define CDCPBC_AL_A_SRC 5
`define CDCPBC_AL_A_POL 4
`define CDCPBC_AL_UPD 3
`define CDCPBC_AL_FIXED 2
`define CDCPBC_AL_RMED 1
`define CDCPBC_AL_CMED 0

`define CDCPBC_RST_PORT 8'hF0
`define CDCPBC_RST_BGAP 8'h07
`define CDCPBC_RST_GAIN 8'h40
`define CDCPBC_RST_ZERO 8'h00
`define CDCPBC_NUM_RESULTS 8

`endif

// file: cdcpbc_config_bank.v
// Configuration bank for port, bandgap, gain, pulse-source, alarm and filter settings
// Operation
// - High nibble at 0x21 sets port direction
// - Low nibble at 0x21 enables port pull-ups
// - 0x22 bit7 triggers refresh at reading end
// - 0x22 bit6 lets processor request refresh
// - 0x22 bit5 keeps bandgap permanently on
// - 0x22 bit4 starts conversion after power-on
// - 0x23 holds gain correction low byte
// - 0x27 high nibble selects pulse IF1 source
// - 0x27 low nibble selects pulse IF0 source
// - 0x28 stores capacitance ratio selection
// - 0x29 stores resistance ratio selection
// - Alarm source bits choose Z or Theta
// - Alarms drive ports 0 and 1 with polarity
// - 0x2A bit3 holds results until read
// - 0x2A bits1,0 enable median filters
`timescale 1ns/1ps
`include "cdcpbc_consts.vh"

module cdcpbc_config_bank #(
    parameter NUM_RESULTS = `CDCPBC_NUM_RESULTS
) (
    input wire clk,
    input wire rst,
    input wire regWrite,
    input wire regRead,
    input wire [5:0] regAddr,
    input wire [7:0] regWriteData,
    output reg [7:0] regReadData,
    output reg [3:0] portDirection,
    output reg [3:0] portPullupEnable,
    output reg readingEndRefresh,
    output reg processorRefresh,
    output reg referenceAlwaysOn,
    output reg powerOnAutoConvert,
    output reg [7:0] gainCorrection,
    output reg [7:0] referenceTiming,
    output reg [3:0] pulseIf1Source,
    output reg [3:0] pulseIf0Source,
    output reg [7:0] pulseIf1Result,
    output reg [7:0] pulseIf0Result,
    output reg [7:0] capRatioSelect,
    output reg [7:0] resRatioSelect,
    output reg [1:0] alarmOut,
    output reg [1:0] alarmOutEnable,
    output reg [7:0] resultUpdateEnable,
    output reg [1:0] medianFilterEnable,
    input wire readingEnd,
    input wire processorRefreshReq,
    output reg bandgapRefresh,
    output reg bandgapEnable,
    input wire powerOnDone,
    output reg autoConvertStart,
    input wire [NUM_RESULTS*8-1:0] resultBytes,
    input wire [NUM_RESULTS-1:0] resultUpdated,
    input wire [NUM_RESULTS-1:0] resultRead,
    input wire [1:0] alarmZ,
    input wire [1:0] alarmTheta
);

    reg [7:0] portReg;
    reg [7:0] bgapReg;
    reg [7:0] alarmReg;
    reg autoDone;
    reg [NUM_RESULTS-1:0] unreadResult;
    reg [7:0] next_readData;
    wire [7:0] gatedWrite;
    integer i;

    function [7:0] pickResult;
        input [3:0] sel;
        input [NUM_RESULTS*8-1:0] bytes;
        integer k;
        begin
            pickResult = 8'h00;
            for (k = 0; k < NUM_RESULTS; k = k + 1) begin
                if (sel == k[3:0]) begin
                    pickResult = bytes[k*8 +: 8];
                end
            end
        end
    endfunction

    // Fixed field forced so a careless write cannot set it
    assign gatedWrite = regWriteData & ~(8'h01 << `CDCPBC_AL_FIXED);

    always @(posedge clk) begin
        if (rst) begin
            portReg <= `CDCPBC_RST_PORT;
            bgapReg <= `CDCPBC_RST_BGAP;
            gainCorrection <= `CDCPBC_RST_GAIN;
            referenceTiming <= `CDCPBC_RST_ZERO;
            pulseIf1Source <= 4'h0;
            pulseIf0Source <= 4'h0;
            capRatioSelect <= `CDCPBC_RST_ZERO;
            resRatioSelect <= `CDCPBC_RST_ZERO;
            alarmReg <= `CDCPBC_RST_ZERO;
        end else if (regWrite) begin
            case (regAddr)
                `CDCPBC_OFF_PORT: portReg <= regWriteData;
                `CDCPBC_OFF_BGAP: bgapReg <= regWriteData;
                `CDCPBC_OFF_GAIN: gainCorrection <= regWriteData;
                `CDCPBC_OFF_BGTIME: referenceTiming <= regWriteData;
                `CDCPBC_OFF_PULSE: begin
                    pulseIf1Source <= regWriteData[`CDCPBC_PULSE1_MSB:`CDCPBC_PULSE1_LSB];
                    pulseIf0Source <= regWriteData[`CDCPBC_PULSE0_MSB:`CDCPBC_PULSE0_LSB];
                end
                `CDCPBC_OFF_CRATIO: capRatioSelect <= regWriteData;
                `CDCPBC_OFF_RRATIO: resRatioSelect <= regWriteData;
                `CDCPBC_OFF_ALARM: alarmReg <= gatedWrite;
                default: begin
                end
            endcase
        end
    end

    always @* begin
        case (regAddr)
            `CDCPBC_OFF_PORT: next_readData = portReg;
            `CDCPBC_OFF_BGAP: next_readData = bgapReg;
            `CDCPBC_OFF_GAIN: next_readData = gainCorrection;
            `CDCPBC_OFF_BGTIME: next_readData = referenceTiming;
            `CDCPBC_OFF_PULSE: next_readData = {pulseIf1Source, pulseIf0Source};
            `CDCPBC_OFF_CRATIO: next_readData = capRatioSelect;
            `CDCPBC_OFF_RRATIO: next_readData = resRatioSelect;
            `CDCPBC_OFF_ALARM: next_readData = alarmReg;
            default: next_readData = 8'h00;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            regReadData <= 8'h00;
        end else if (regRead) begin
            regReadData <= next_readData;
        end
    end

    // Decoded fields, registered so every output leaves a flip-flop
    always @(posedge clk) begin
        if (rst) begin
            portDirection <= 4'hF;
            portPullupEnable <= 4'h0;
            readingEndRefresh <= 1'b0;
            processorRefresh <= 1'b0;
            referenceAlwaysOn <= 1'b0;
            powerOnAutoConvert <= 1'b0;
            medianFilterEnable <= 2'h0;
            alarmOutEnable <= 2'h0;
        end else begin
            portDirection <= portReg[`CDCPBC_PORT_DIR_MSB:`CDCPBC_PORT_DIR_LSB];
            portPullupEnable <= portReg[`CDCPBC_PORT_PU_MSB:`CDCPBC_PORT_PU_LSB];
            readingEndRefresh <= bgapReg[`CDCPBC_BG_READEND];
            processorRefresh <= bgapReg[`CDCPBC_BG_PROC];
            referenceAlwaysOn <= bgapReg[`CDCPBC_REFERENCE_ALWAYS_ON];
            powerOnAutoConvert <= bgapReg[`CDCPBC_BG_AUTO];
            medianFilterEnable <= {alarmReg[`CDCPBC_AL_RMED], alarmReg[`CDCPBC_AL_CMED]};
            // Alarms only reach a port configured as output
            alarmOutEnable <= ~portReg[`CDCPBC_PORT_DIR_LSB+1:`CDCPBC_PORT_DIR_LSB];
        end
    end

    // Bandgap control
    always @(posedge clk) begin
        if (rst) begin
            bandgapRefresh <= 1'b0;
            bandgapEnable <= 1'b0;
        end else begin
            bandgapRefresh <= (bgapReg[`CDCPBC_BG_READEND] & readingEnd)
                | (bgapReg[`CDCPBC_BG_PROC] & processorRefreshReq);
            // Pulsed mode lets the refresh strobe power it briefly
            bandgapEnable <= bgapReg[`CDCPBC_REFERENCE_ALWAYS_ON] | bandgapRefresh;
        end
    end

    // One start per power-on; rearmed only by reset
    always @(posedge clk) begin
        if (rst) begin
            autoDone <= 1'b0;
            autoConvertStart <= 1'b0;
        end else begin
            autoConvertStart <= 1'b0;
            if (powerOnDone && !autoDone) begin
                autoDone <= 1'b1;
                autoConvertStart <= bgapReg[`CDCPBC_BG_AUTO];
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            pulseIf1Result <= 8'h00;
            pulseIf0Result <= 8'h00;
        end else begin
            pulseIf1Result <= pickResult(pulseIf1Source, resultBytes);
            pulseIf0Result <= pickResult(pulseIf0Source, resultBytes);
        end
    end

    // Alarm sources and polarity; polarity 1 inverts the active-high alarm
    always @(posedge clk) begin
        if (rst) begin
            alarmOut <= 2'h0;
        end else begin
            alarmOut[1] <= (alarmReg[`CDCPBC_AL_B_SRC] ? alarmTheta[1] : alarmZ[1])
                ^ alarmReg[`CDCPBC_AL_B_POL];
            alarmOut[0] <= (alarmReg[`CDCPBC_AL_A_SRC] ? alarmTheta[0] : alarmZ[0])
                ^ alarmReg[`CDCPBC_AL_A_POL];
        end
    end

    // Unread tracking; a new update wins over a same-cycle read
    always @(posedge clk) begin
        if (rst) begin
            unreadResult <= {NUM_RESULTS{1'b0}};
            resultUpdateEnable <= 8'hFF;
        end else begin
            for (i = 0; i < NUM_RESULTS; i = i + 1) begin
                if (resultUpdated[i]) begin
                    unreadResult[i] <= 1'b1;
                end else if (resultRead[i]) begin
                    unreadResult[i] <= 1'b0;
                end
                resultUpdateEnable[i] <= ~alarmReg[`CDCPBC_AL_UPD] | ~unreadResult[i]
                    | resultRead[i];
            end
        end
    end

endmodule

// file: cdcpbc_chk.sv
// Concurrent checks on the configuration bank ports
`timescale 1ns/1ps
module cdcpbc_chk #(
    parameter NUM_RESULTS = 8
) (
    input wire clk,
    input wire rst,
    input wire regWrite,
    input wire [5:0] regAddr,
    input wire [7:0] regWriteData,
    input wire [3:0] portDirection,
    input wire [3:0] portPullupEnable,
    input wire readingEnd,
    input wire processorRefreshReq,
    input wire readingEndRefresh,
    input wire processorRefresh,
    input wire bandgapRefresh,
    input wire referenceAlwaysOn,
    input wire bandgapEnable,
    input wire powerOnDone,
    input wire powerOnAutoConvert,
    input wire autoConvertStart,
    input wire [1:0] alarmOutEnable,
    input wire [NUM_RESULTS-1:0] resultRead,
    input wire [NUM_RESULTS-1:0] resultUpdateEnable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Decoded copy lags the write edge by two edges
    sequence wrPort;
        regWrite && regAddr == 6'h21 ##2 1'b1;
    endsequence
    port_dir_a: assert property (wrPort |-> portDirection == $past(regWriteData[7:4], 2))
        else $error("port direction mismatch");
    port_pullup_a: assert property (wrPort |-> portPullupEnable == $past(regWriteData[3:0], 2))
        else $error("pull-up enable mismatch");
    end_refresh_a: assert property (readingEnd && !processorRefreshReq |=> bandgapRefresh == readingEndRefresh)
        else $error("reading-end refresh mismatch");
    proc_refresh_a: assert property (processorRefreshReq && !readingEnd |=> bandgapRefresh == processorRefresh)
        else $error("processor refresh mismatch");
    ref_enable_a: assert property (bandgapEnable == (referenceAlwaysOn || $past(bandgapRefresh)))
        else $error("reference enable mismatch");
    auto_start_a: assert property (autoConvertStart |-> powerOnAutoConvert && $past(powerOnDone))
        else $error("unexpected automatic start");
    alarm_drive_a: assert property (alarmOutEnable == ~portDirection[1:0])
        else $error("alarm drive enable mismatch");
    read_release_a: assert property (|resultRead |=> (resultUpdateEnable & $past(resultRead)) == $past(resultRead))
        else $error("read did not release update");
endmodule
bind cdcpbc_config_bank cdcpbc_chk #(.NUM_RESULTS(NUM_RESULTS)) chk_i (.*);

// file: cdcpbc_host.sv
// Host model issuing single-byte register writes and reads
`timescale 1ns/1ps
module cdcpbc_host (
    input wire clk,
    input wire [7:0] regReadData,
    output reg regWrite,
    output reg regRead,
    output reg [5:0] regAddr,
    output reg [7:0] regWriteData
);
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 6'h00;
        regWriteData = 8'h00;
    end
    // Forces the 0x22 low nibble to 7 and clears 0x2A bit2 before every write
    task wr(input [5:0] a, input [7:0] d);
        begin
            if (a == 6'h22) d[3:0] = 4'h7;
            if (a == 6'h2A) d[2] = 1'b0;
            @(posedge clk);
            #1 regAddr = a;
            regWriteData = d;
            regWrite = 1'b1;
            @(posedge clk);
            #1 regWrite = 1'b0;
            // Released lines show garbage, not the last value
            regWriteData = ~d;
            regAddr = ~a;
        end
    endtask
    task rd(input [5:0] a, output [7:0] q);
        begin
            @(posedge clk);
            #1 regAddr = a;
            regRead = 1'b1;
            @(posedge clk);
            #1 regRead = 1'b0;
            regAddr = ~a;
            @(posedge clk);
            #1 q = regReadData;
        end
    endtask
endmodule

// file: cdc_port_bandgap_pulse_config_bench.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
module cdc_port_bandgap_pulse_config_bench;
    reg clk, rst, readingEnd, processorRefreshReq, powerOnDone;
    reg [63:0] resultBytes;
    reg [7:0] resultUpdated, resultRead, q;
    reg [1:0] alarmZ, alarmTheta;
    wire regWrite, regRead, readingEndRefresh, processorRefresh, referenceAlwaysOn, powerOnAutoConvert;
    wire bandgapRefresh, bandgapEnable, autoConvertStart;
    wire [5:0] regAddr;
    wire [7:0] regWriteData, regReadData, gainCorrection, referenceTiming, pulseIf1Result, pulseIf0Result;
    wire [7:0] capRatioSelect, resRatioSelect, resultUpdateEnable;
    wire [3:0] portDirection, portPullupEnable, pulseIf1Source, pulseIf0Source;
    wire [1:0] alarmOut, alarmOutEnable, medianFilterEnable;
    integer n_errors = 0, check_count = 0, k;
    cdcpbc_host host (.clk, .regReadData, .regWrite, .regRead, .regAddr, .regWriteData);
    cdcpbc_config_bank #(.NUM_RESULTS(8)) dut (.clk, .rst, .regWrite, .regRead, .regAddr, .regWriteData,
        .regReadData, .portDirection, .portPullupEnable, .readingEndRefresh, .processorRefresh,
        .referenceAlwaysOn, .powerOnAutoConvert, .gainCorrection, .referenceTiming, .pulseIf1Source,
        .pulseIf0Source, .pulseIf1Result, .pulseIf0Result, .capRatioSelect, .resRatioSelect, .alarmOut,
        .alarmOutEnable, .resultUpdateEnable, .medianFilterEnable, .readingEnd, .processorRefreshReq,
        .bandgapRefresh, .bandgapEnable, .powerOnDone, .autoConvertStart, .resultBytes, .resultUpdated,
        .resultRead, .alarmZ, .alarmTheta);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task chk(input [7:0] got, input [7:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task rdchk(input [5:0] a, input [7:0] e);
        begin
            host.rd(a, q);
            chk(q, e);
        end
    endtask
    task step;
        begin
            @(posedge clk);
            #1;
        end
    endtask
    task trig(input re, input pr, input e);
        begin
            step;
            readingEnd = re;
            processorRefreshReq = pr;
            step;
            // Refresh strobe stands only for the cycle after the trigger edge
            chk({7'h00, bandgapRefresh}, {7'h00, e});
            readingEnd = 1'b0;
            processorRefreshReq = 1'b0;
        end
    endtask
    task t_reset;
        begin
            rdchk(6'h21, 8'hF0);
            rdchk(6'h22, 8'h07);
            rdchk(6'h23, 8'h40);
            rdchk(6'h24, 8'h00);
            $display("reset values done");
        end
    endtask
    task t_regs;
        begin
            host.wr(6'h21, 8'hA5);
            host.wr(6'h24, 8'hFF);
            host.wr(6'h23, 8'h00);
            host.wr(6'h28, 8'h5A);
            host.wr(6'h29, 8'hC3);
            host.wr(6'h26, 8'h3C);
            chk(referenceTiming, 8'h3C);
            rdchk(6'h21, 8'hA5);
            chk({portDirection, portPullupEnable}, 8'hA5);
            rdchk(6'h24, 8'h00);
            rdchk(6'h3F, 8'h00);
            chk(gainCorrection, 8'h00);
            chk(capRatioSelect, 8'h5A);
            chk(resRatioSelect, 8'hC3);
            $display("register access done");
        end
    endtask
    task t_bandgap;
        begin
            host.wr(6'h22, 8'h40);
            rdchk(6'h22, 8'h47);
            trig(1'b1, 1'b0, 1'b0);
            trig(1'b0, 1'b1, 1'b1);
            chk({7'h00, bandgapEnable}, 8'h00);
            chk({4'h0, readingEndRefresh, processorRefresh, referenceAlwaysOn, powerOnAutoConvert}, 8'h04);
            host.wr(6'h22, 8'hB0);
            rdchk(6'h22, 8'hB7);
            trig(1'b1, 1'b0, 1'b1);
            trig(1'b0, 1'b1, 1'b0);
            chk({7'h00, bandgapEnable}, 8'h01);
            chk({4'h0, readingEndRefresh, processorRefresh, referenceAlwaysOn, powerOnAutoConvert}, 8'h0B);
            powerOnDone = 1'b1;
            k = 0;
            repeat (6) begin
                step;
                k = k + autoConvertStart;
            end
            chk(k[7:0], 8'h01);
            $display("bandgap and power_on_auto_convert done");
        end
    endtask
    task t_outputs;
        begin
            host.wr(6'h27, 8'h52);
            host.wr(6'h21, 8'hC0);
            host.wr(6'h2A, 8'h93);
            rdchk(6'h27, 8'h52);
            chk({pulseIf1Source, pulseIf0Source}, 8'h52);
            chk(pulseIf1Result, 8'h55);
            chk(pulseIf0Result, 8'h22);
            rdchk(6'h2A, 8'h93);
            chk({6'h00, alarmOut}, 8'h02);
            chk({6'h00, alarmOutEnable}, 8'h03);
            chk({6'h00, medianFilterEnable}, 8'h03);
            host.wr(6'h2A, 8'h08);
            rdchk(6'h2A, 8'h08);
            resultUpdated = 8'h08;
            step;
            resultUpdated = 8'h00;
            step;
            chk(resultUpdateEnable, 8'hF7);
            resultRead = 8'h08;
            step;
            resultRead = 8'h00;
            step;
            chk(resultUpdateEnable, 8'hFF);
            $display("pulse, alarm and update done");
        end
    endtask
    task tally_and_finish;
        begin
            $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
            if (n_errors == 0 && check_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        rst = 1'b1;
        {readingEnd, processorRefreshReq, powerOnDone} = 3'b000;
        resultBytes = 64'h7766554433221100;
        {resultUpdated, resultRead} = 16'h0000;
        alarmZ = 2'b01;
        alarmTheta = 2'b10;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        t_reset;
        t_regs;
        t_bandgap;
        t_outputs;
        tally_and_finish;
    end
endmodule
